// ---- core/mem_map_pkg.sv ----
package mem_map_pkg;

  // ----------------------------------------
  // widths and sizes
  // ----------------------------------------
  localparam int ADDR_W = 16;
  localparam int PC_W = 11;
  localparam int FLASH_WORDS = 2048;
  localparam int SRAM_BYTES = 256;
  localparam int ACCESS_CYCLES = 2;
  localparam logic [10:0] PC_FIRST = 11'h000;

  // ----------------------------------------
  // data space map
  // ----------------------------------------
  localparam logic [15:0] IO_LAST = 16'h003f;
  localparam logic [15:0] BIT_IO_LAST = 16'h001f;
  localparam logic [15:0] SRAM_FIRST = 16'h0040;
  localparam logic [15:0] SRAM_LAST = 16'h013f;
  localparam logic [15:0] DIRECT_FIRST = 16'h0040;
  localparam logic [15:0] DIRECT_LAST = 16'h00bf;
  localparam logic [15:0] LOCK_FIRST = 16'h3f00;
  localparam logic [15:0] LOCK_LAST = 16'h3f01;
  localparam logic [15:0] CFG_FIRST = 16'h3f40;
  localparam logic [15:0] CFG_LAST = 16'h3f41;
  localparam logic [15:0] CAL_FIRST = 16'h3f80;
  localparam logic [15:0] CAL_LAST = 16'h3f81;
  localparam logic [15:0] ID_FIRST = 16'h3fc0;
  localparam logic [15:0] ID_LAST = 16'h3fc3;
  localparam logic [15:0] FLASH_FIRST = 16'h4000;
  localparam logic [15:0] FLASH_LAST = 16'h47ff;

  // ----------------------------------------
  // sram index/window registers in i/o space
  // ----------------------------------------
  localparam logic [5:0] WINDOW_IO_ADDR = 6'h1f;
  localparam logic [5:0] INDEX_IO_ADDR = 6'h20;

  // ----------------------------------------
  // non-volatile space codes on nvm_space
  // ----------------------------------------
  localparam logic [1:0] NVM_LOCK = 2'h0;
  localparam logic [1:0] NVM_CFG = 2'h1;
  localparam logic [1:0] NVM_CAL = 2'h2;
  localparam logic [1:0] NVM_ID = 2'h3;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {
    KIND_DIRECT = 2'h0,
    KIND_POINTER = 2'h1,
    KIND_IO = 2'h2,
    KIND_BIT = 2'h3
  } op_kind_t;

  typedef enum logic [1:0] {
    PTR_PLAIN = 2'h0,
    PTR_PRE_DEC = 2'h1,
    PTR_POST_INC = 2'h2
  } ptr_mode_t;

  typedef enum logic [2:0] {
    RG_IO, RG_SRAM, RG_LOCK, RG_CFG, RG_CAL, RG_ID, RG_FLASH, RG_NONE
  } region_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ACCESS = 2'b10
  } state_t;

endpackage

// ---- core/sram_store.sv ----
`timescale 1ns/100ps
module sram_store #(
  parameter int DEPTH = 256,
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [$clog2(DEPTH)-1:0] addr,
  input wire logic [WIDTH-1:0] wdata,
  output logic [WIDTH-1:0] rdata
);

  logic [WIDTH-1:0] mem [DEPTH];

  // ----------------------------------------
  // registered read, write port
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    rdata <= mem[addr];
  end

endmodule

// ---- core/data_memory_decoder.sv ----
`timescale 1ns/100ps
// Summary of operation
// - flash is 2048 words, 11-bit program_counter
// - flash mapped into data space at 0x4000
// - core writes to flash are dropped
// - 0x00-0x3f i/o, 0x40-0x13f sram
// - lock bits and flash read-only to core
// - nvm sections at fixed addresses, rest reserved
// - load_direct/direct_write_op reach 0x40-0xbf only
// - index register uses physical sram addresses
// - sram data access takes two cycles
// - direct, indirect, pre-decrement, post-increment pointers
// - pointer accesses reach whole data space
// - i/o instructions reach all 64 locations
// - bit ops only on i/o 0x00-0x1f
// - window write stores byte at index
// - window read fetches byte at index
// - bit ops touch only the addressed bit
// - index/window undefined after reset, load first
// - index addresses sram bytes 0 to 255
// - index at i/o 0x20, window at 0x1f
module data_memory_decoder
  import mem_map_pkg::*;
#(
  parameter int SRAM_DEPTH = SRAM_BYTES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic req,
  input wire op_kind_t req_kind,
  input wire ptr_mode_t req_ptr_mode,
  input wire logic req_write,
  input wire logic [15:0] req_addr,
  input wire logic [15:0] ptr_in,
  input wire logic [7:0] req_wdata,
  input wire logic [2:0] bit_index,
  input wire logic bit_value,
  output logic ready,
  output logic ack,
  output logic [7:0] rdata,
  output logic bit_result,
  output logic refused,
  output logic [15:0] ptr_out,
  output logic ptr_we,
  output logic [5:0] io_addr,
  output logic [7:0] io_wdata,
  output logic [7:0] io_wmask,
  output logic io_we,
  output logic io_re,
  input wire logic [7:0] io_rdata,
  output logic nvm_re,
  output logic [1:0] nvm_space,
  output logic [1:0] nvm_offset,
  input wire logic [7:0] nvm_rdata,
  input wire logic [10:0] program_counter,
  output logic [10:0] flash_word_addr,
  input wire logic [15:0] flash_rdata,
  output logic [15:0] instr_word,
  output logic instr_valid
);

  // ----------------------------------------
  // functions
  // ----------------------------------------
  function automatic region_t decode_region(input logic [15:0] a);
    region_t r;
    r = RG_NONE;
    if (a <= IO_LAST) r = RG_IO;
    else if (a >= SRAM_FIRST && a <= SRAM_LAST) r = RG_SRAM;
    else if (a >= LOCK_FIRST && a <= LOCK_LAST) r = RG_LOCK;
    else if (a >= CFG_FIRST && a <= CFG_LAST) r = RG_CFG;
    else if (a >= CAL_FIRST && a <= CAL_LAST) r = RG_CAL;
    else if (a >= ID_FIRST && a <= ID_LAST) r = RG_ID;
    else if (a >= FLASH_FIRST && a <= FLASH_LAST) r = RG_FLASH;
    return r;
  endfunction

  function automatic logic [15:0] eff_addr(input op_kind_t k, input ptr_mode_t m,
                                           input logic [15:0] a, input logic [15:0] p);
    logic [15:0] e;
    e = a;
    if (k == KIND_POINTER) begin
      e = (m == PTR_PRE_DEC) ? p - 16'h0001 : p;
    end else if (k != KIND_DIRECT) begin
      e = {10'h000, a[5:0]};
    end
    return e;
  endfunction

  // ----------------------------------------
  // request decode
  // ----------------------------------------
  state_t state;
  logic take;
  logic [15:0] addr_c;
  region_t region_c;
  logic allowed_c;
  logic win_data_c;
  logic win_index_c;
  logic is_bit;
  logic sram_we;
  logic [7:0] sram_addr;
  logic [7:0] sram_wdata;
  logic [7:0] sram_q;
  logic [7:0] index_reg;
  logic [7:0] hold_q;
  logic sel_sram;
  logic [2:0] bit_index_q;
  logic flash_data_read;

  assign ready = (state == ST_IDLE);
  assign take = req && ready;
  assign is_bit = (req_kind == KIND_BIT);
  assign addr_c = eff_addr(req_kind, req_ptr_mode, req_addr, ptr_in);
  assign region_c = decode_region(addr_c);
  assign win_data_c = (region_c == RG_IO) && (addr_c[5:0] == WINDOW_IO_ADDR);
  assign win_index_c = (region_c == RG_IO) && (addr_c[5:0] == INDEX_IO_ADDR);

  always_comb begin
    unique case (req_kind)
      KIND_DIRECT: allowed_c = (addr_c >= DIRECT_FIRST) && (addr_c <= DIRECT_LAST);
      KIND_BIT: allowed_c = (addr_c <= BIT_IO_LAST);
      KIND_IO: allowed_c = 1'b1;
      KIND_POINTER: allowed_c = 1'b1;
    endcase
  end

  // ----------------------------------------
  // sram and window path
  // ----------------------------------------
  assign sram_we = take && allowed_c && req_write && !is_bit &&
                   ((region_c == RG_SRAM) || win_data_c);
  assign sram_addr = win_data_c ? index_reg : addr_c[7:0];
  assign sram_wdata = req_wdata;

  sram_store #(
    .DEPTH(SRAM_DEPTH),
    .WIDTH(8)
  ) u_store (
    .clk(clk),
    .we(sram_we),
    .addr(sram_addr),
    .wdata(sram_wdata),
    .rdata(sram_q)
  );

  // index register has no reset value
  always_ff @(posedge clk) begin
    if (take && allowed_c && req_write && win_index_c) begin
      index_reg <= req_wdata;
    end
  end

  // ----------------------------------------
  // i/o, nvm and flash ports
  // ----------------------------------------
  logic io_hit;
  assign io_hit = take && allowed_c && (region_c == RG_IO) && !win_data_c && !win_index_c;
  assign io_addr = addr_c[5:0];
  assign io_we = io_hit && req_write;
  assign io_re = io_hit && !req_write;
  assign io_wmask = is_bit ? 8'(8'h01 << bit_index) : 8'hff;
  assign io_wdata = is_bit ? (bit_value ? io_wmask : 8'h00) : req_wdata;

  assign nvm_re = take && allowed_c && !req_write &&
                  (region_c == RG_LOCK || region_c == RG_CFG ||
                   region_c == RG_CAL || region_c == RG_ID);
  assign nvm_offset = addr_c[1:0];
  always_comb begin
    unique case (region_c)
      RG_CFG: nvm_space = NVM_CFG;
      RG_CAL: nvm_space = NVM_CAL;
      RG_ID: nvm_space = NVM_ID;
      default: nvm_space = NVM_LOCK;
    endcase
  end

  assign flash_data_read = take && allowed_c && !req_write && (region_c == RG_FLASH);
  assign flash_word_addr = flash_data_read ? addr_c[11:1] : program_counter;

  always_ff @(posedge clk) begin
    if (rst) begin
      instr_word <= 16'h0000;
      instr_valid <= 1'b0;
    end else begin
      instr_word <= flash_rdata;
      instr_valid <= !flash_data_read;
    end
  end

  // ----------------------------------------
  // access sequencing
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE: if (take) state <= ST_ACCESS;
        ST_ACCESS: state <= ST_IDLE;
      endcase
    end
  end

  assign ack = (state == ST_ACCESS);

  // capture read source at the take edge
  always_ff @(posedge clk) begin
    if (rst) begin
      hold_q <= 8'h00;
      sel_sram <= 1'b0;
      refused <= 1'b0;
      bit_index_q <= 3'h0;
    end else if (take) begin
      sel_sram <= allowed_c && ((region_c == RG_SRAM) || win_data_c);
      refused <= !allowed_c;
      bit_index_q <= bit_index;
      if (!allowed_c || req_write) hold_q <= 8'h00;
      else if (win_index_c) hold_q <= index_reg;
      else if (region_c == RG_IO) hold_q <= io_rdata;
      else if (nvm_re) hold_q <= nvm_rdata;
      else if (region_c == RG_FLASH) hold_q <= addr_c[0] ? flash_rdata[15:8] : flash_rdata[7:0];
      else hold_q <= 8'h00;
    end
  end

  assign rdata = sel_sram ? sram_q : hold_q;
  assign bit_result = rdata[bit_index_q];

  // pointer update
  logic ptr_upd;
  always_ff @(posedge clk) begin
    if (rst) begin
      ptr_out <= 16'h0000;
      ptr_upd <= 1'b0;
    end else if (take) begin
      ptr_upd <= (req_kind == KIND_POINTER) && (req_ptr_mode != PTR_PLAIN);
      if (req_ptr_mode == PTR_POST_INC) ptr_out <= ptr_in + 16'h0001;
      else ptr_out <= addr_c;
    end
  end
  assign ptr_we = ack && ptr_upd;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_ack_once;
    ack ##1 !ack;
  endsequence

  sequence s_take_post_inc;
    take && req_kind == KIND_POINTER && req_ptr_mode == PTR_POST_INC;
  endsequence

  chk_access_two_cycles: assert property (@(posedge clk) disable iff (rst)
    take |=> s_ack_once) else $error("access did not complete in two cycles");

  chk_flash_write_drop: assert property (@(posedge clk) disable iff (rst)
    take && req_write && region_c == RG_FLASH |-> !sram_we && !io_we && !nvm_re)
    else $error("flash write reached a store");

  chk_nvm_read_only: assert property (@(posedge clk) disable iff (rst)
    take && req_write && req_kind == KIND_POINTER &&
    region_c inside {RG_LOCK, RG_CFG, RG_CAL, RG_ID}
    |-> !nvm_re && !sram_we && !io_we ##1 ack && !refused)
    else $error("nvm accessed by a write");

  chk_direct_range_limit: assert property (@(posedge clk) disable iff (rst)
    take && req_kind == KIND_DIRECT && (addr_c < DIRECT_FIRST || addr_c > DIRECT_LAST)
    |-> !sram_we && !io_we && !nvm_re ##1 ack && refused)
    else $error("direct access out of range");

  chk_bit_range_limit: assert property (@(posedge clk) disable iff (rst)
    take && is_bit && addr_c > BIT_IO_LAST |-> !io_we ##1 refused)
    else $error("bit op above 0x1f accepted");

  chk_bit_single_mask: assert property (@(posedge clk) disable iff (rst)
    io_we && is_bit |-> $onehot(io_wmask)) else $error("bit op touched several bits");

  chk_window_write_index: assert property (@(posedge clk) disable iff (rst)
    take && allowed_c && req_write && win_data_c && !is_bit |->
    sram_we && sram_addr == index_reg)
    else $error("window write missed index");

  chk_window_read_sram: assert property (@(posedge clk) disable iff (rst)
    take && allowed_c && !req_write && win_data_c |=> ack && rdata == sram_q && sel_sram)
    else $error("window read not from sram");

  chk_post_inc_ptr: assert property (@(posedge clk) disable iff (rst)
    s_take_post_inc |=> ptr_we && ptr_out == $past(ptr_in) + 16'h0001)
    else $error("post-increment wrong");

  chk_virtual_sram_map: assert property (@(posedge clk) disable iff (rst)
    take && region_c == RG_SRAM |-> sram_addr == addr_c[7:0])
    else $error("virtual to physical map wrong");

  chk_flash_word_map: assert property (@(posedge clk) disable iff (rst)
    flash_data_read |-> flash_word_addr == 11'(addr_c - FLASH_FIRST) >> 1)
    else $error("flash word address wrong");

  chk_reserved_zero: assert property (@(posedge clk) disable iff (rst)
    take && !req_write && region_c == RG_NONE |=> ack && rdata == 8'h00)
    else $error("reserved read not zero");

endmodule

// ---- dv/dmem_partner.sv ----
`timescale 1ns/100ps
module dmem_partner (
  input wire logic clk,
  input wire logic rst,
  input wire logic [5:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_wmask,
  input wire logic io_we,
  input wire logic io_re,
  output logic [7:0] io_rdata,
  input wire logic nvm_re,
  input wire logic [1:0] nvm_space,
  input wire logic [1:0] nvm_offset,
  output logic [7:0] nvm_rdata,
  input wire logic [10:0] flash_word_addr,
  output logic [15:0] flash_rdata
);
  // ----------------------------------------
  // i/o registers, nvm and flash contents
  // ----------------------------------------
  logic [7:0] regs [64];
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < 64; i++) begin
        regs[i] <= 8'h00;
      end
    end else if (io_we) begin
      regs[io_addr] <= (regs[io_addr] & ~io_wmask) | (io_wdata & io_wmask);
    end
  end
  assign io_rdata = io_re ? regs[io_addr] : ~regs[io_addr];
  assign nvm_rdata = nvm_re ? {2'h2, nvm_space, 2'h1, nvm_offset} : 8'h55;
  assign flash_rdata = {flash_word_addr[7:0] ^ 8'h5a, flash_word_addr[10:3]};
endmodule

// ---- dv/data_memory_decoder_tb_top.sv ----
`timescale 1ns/100ps
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin err_count++; \
  $display("[ERR] %s exp %h got %h", n, e, s); end end
module data_memory_decoder_tb_top
  import mem_map_pkg::*;
;
  logic clk, rst, req, req_write, bit_value, ready, ack, bit_result, refused, ptr_we;
  logic io_we, io_re, nvm_re, instr_valid, gbit, gref, gpwe, twe, giv;
  op_kind_t req_kind;
  ptr_mode_t req_ptr_mode;
  logic [15:0] req_addr, ptr_in, ptr_out, flash_rdata, instr_word, a, gpo;
  logic [7:0] req_wdata, rdata, io_wdata, io_wmask, io_rdata, nvm_rdata, got, tmask, d;
  logic [2:0] bit_index;
  logic [5:0] io_addr;
  logic [1:0] nvm_space, nvm_offset;
  logic [10:0] program_counter, flash_word_addr;
  logic [31:0] r;
  logic [15:0] rsv [7] = '{16'h0140, 16'h3eff, 16'h3f02, 16'h3fc4, 16'h3fff, 16'h4800, 16'hffff};
  int err_count, checked, seed;

  data_memory_decoder dut_u (
    .clk(clk), .rst(rst), .req(req), .req_kind(req_kind), .req_ptr_mode(req_ptr_mode),
    .req_write(req_write), .req_addr(req_addr), .ptr_in(ptr_in), .req_wdata(req_wdata),
    .bit_index(bit_index), .bit_value(bit_value), .ready(ready), .ack(ack), .rdata(rdata),
    .bit_result(bit_result), .refused(refused), .ptr_out(ptr_out), .ptr_we(ptr_we),
    .io_addr(io_addr), .io_wdata(io_wdata), .io_wmask(io_wmask), .io_we(io_we),
    .io_re(io_re), .io_rdata(io_rdata), .nvm_re(nvm_re), .nvm_space(nvm_space),
    .nvm_offset(nvm_offset), .nvm_rdata(nvm_rdata), .program_counter(program_counter),
    .flash_word_addr(flash_word_addr), .flash_rdata(flash_rdata),
    .instr_word(instr_word), .instr_valid(instr_valid)
  );
  dmem_partner far_u (
    .clk(clk), .rst(rst), .io_addr(io_addr), .io_wdata(io_wdata), .io_wmask(io_wmask),
    .io_we(io_we), .io_re(io_re), .io_rdata(io_rdata), .nvm_re(nvm_re),
    .nvm_space(nvm_space), .nvm_offset(nvm_offset), .nvm_rdata(nvm_rdata),
    .flash_word_addr(flash_word_addr), .flash_rdata(flash_rdata)
  );

  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [15:0] fword(input logic [10:0] w);
    return {w[7:0] ^ 8'h5a, w[10:3]};
  endfunction

  function automatic logic [7:0] fbyte(input logic [15:0] x);
    logic [15:0] v;
    v = fword(x[11:1]);
    return x[0] ? v[15:8] : v[7:0];
  endfunction

  task automatic acc(input op_kind_t k, input ptr_mode_t m, input logic w,
                     input logic [15:0] ad, input logic [7:0] wd, input logic [2:0] bi);
    @(posedge clk);
    req <= 1'b1;
    req_kind <= k;
    req_ptr_mode <= m;
    req_write <= w;
    req_addr <= ad;
    ptr_in <= ad;
    req_wdata <= wd;
    bit_index <= bi;
    bit_value <= wd[0];
    @(negedge clk);
    `CHK("ready", 1'b1, ready)
    twe = io_we;
    tmask = io_wmask;
    @(posedge clk);
    req <= 1'b0;
    @(negedge clk);
    `CHK("ack", 1'b1, ack)
    `CHK("busy", 1'b0, ready)
    got = rdata;
    gbit = bit_result;
    gref = refused;
    gpwe = ptr_we;
    gpo = ptr_out;
    giv = instr_valid;
  endtask

  task automatic wr(input op_kind_t k, input logic [15:0] ad, input logic [7:0] wd);
    acc(k, PTR_PLAIN, 1'b1, ad, wd, 3'h0);
  endtask

  task automatic rd(input op_kind_t k, input logic [15:0] ad, input logic [7:0] e);
    acc(k, PTR_PLAIN, 1'b0, ad, 8'h00, 3'h0);
    `CHK("rdata", e, got)
  endtask

  task automatic end_sim;
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    end_sim;
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    seed = 75;
    err_count = 0;
    checked = 0;
    {rst, req, req_write, bit_value} = 4'h8;
    req_kind = KIND_DIRECT;
    req_ptr_mode = PTR_PLAIN;
    {req_addr, ptr_in, req_wdata, bit_index, program_counter} = '0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    `CHK("ack_rst", 1'b0, ack)
    for (int i = 0; i < 12; i++) begin
      r = $random(seed);
      a = (i == 0) ? 16'h0040 : (i == 1) ? 16'h00bf : 16'h0040 + {9'h0, r[6:0]};
      wr(KIND_DIRECT, a, r[15:8]);
      `CHK("refused", 1'b0, gref)
      rd(KIND_DIRECT, a, r[15:8]);
      a = 16'h00c0 + {9'h0, r[22:16]};
      wr(KIND_POINTER, a, r[31:24]);
      wr(KIND_IO, {10'h0, INDEX_IO_ADDR}, a[7:0]);
      rd(KIND_IO, {10'h0, WINDOW_IO_ADDR}, r[31:24]);
      wr(KIND_IO, {10'h0, INDEX_IO_ADDR}, r[7:0]);
      wr(KIND_IO, {10'h0, WINDOW_IO_ADDR}, r[23:16]);
      a = (r[7:0] < 8'h40) ? 16'h0100 + {8'h0, r[7:0]} : {8'h0, r[7:0]};
      rd(KIND_POINTER, a, r[23:16]);
      a = 16'h4000 + {5'h0, r[10:0]};
      rd(KIND_POINTER, a, fbyte(a));
      `CHK("instr_valid", 1'b0, giv)
    end
    wr(KIND_POINTER, 16'h00c0, 8'h3c);
    wr(KIND_DIRECT, 16'h00c0, 8'hc3);
    `CHK("refused", 1'b1, gref)
    rd(KIND_DIRECT, 16'h013f, 8'h00);
    `CHK("refused", 1'b1, gref)
    rd(KIND_POINTER, 16'h00c0, 8'h3c);
    wr(KIND_POINTER, 16'h0050, 8'ha5);
    acc(KIND_POINTER, PTR_POST_INC, 1'b0, 16'h0050, 8'h00, 3'h0);
    `CHK("post", {1'b1, 16'h0051, 8'ha5}, {gpwe, gpo, got})
    acc(KIND_POINTER, PTR_PRE_DEC, 1'b0, 16'h0051, 8'h00, 3'h0);
    `CHK("pre", {1'b1, 16'h0050, 8'ha5}, {gpwe, gpo, got})
    rd(KIND_POINTER, 16'h47ff, fbyte(16'h47ff));
    wr(KIND_POINTER, 16'h4000, 8'h00);
    `CHK("refused", 1'b0, gref)
    rd(KIND_POINTER, 16'h4000, fbyte(16'h4000));
    for (int s = 0; s < 4; s++) begin
      for (int o = 0; o < ((s == 3) ? 4 : 2); o++) begin
        a = 16'h3f00 + 16'(s * 64 + o);
        wr(KIND_POINTER, a, 8'h00);
        rd(KIND_POINTER, a, {2'h2, 2'(s), 2'h1, 2'(o)});
      end
    end
    foreach (rsv[i]) begin
      wr(KIND_POINTER, rsv[i], 8'hff);
      rd(KIND_POINTER, rsv[i], 8'h00);
    end
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      a = (r[5:0] == 6'h1f || r[5:0] == 6'h20) ? 16'h0010 : {10'h0, r[5:0]};
      wr(KIND_IO, a, r[15:8]);
      `CHK("io_wmask", 8'hff, tmask)
      rd(KIND_IO, a, r[15:8]);
      rd(KIND_POINTER, a, r[15:8]);
    end
    wr(KIND_IO, 16'h001e, 8'h00);
    for (int b = 0; b < 8; b++) begin
      acc(KIND_BIT, PTR_PLAIN, 1'b1, 16'h001e, 8'h01, 3'(b));
      `CHK("io_wmask", 8'h01 << b, tmask)
    end
    acc(KIND_BIT, PTR_PLAIN, 1'b1, 16'h001e, 8'h00, 3'h3);
    rd(KIND_IO, 16'h001e, 8'hf7);
    acc(KIND_BIT, PTR_PLAIN, 1'b0, 16'h001e, 8'h00, 3'h3);
    `CHK("bit_result", 1'b0, gbit)
    acc(KIND_BIT, PTR_PLAIN, 1'b1, 16'h0020, 8'h01, 3'h0);
    `CHK("bit_refuse", 2'b10, {gref, twe})
    for (int i = 0; i < 6; i++) begin
      r = $random(seed);
      @(posedge clk);
      program_counter <= r[10:0];
      @(posedge clk);
      @(negedge clk);
      `CHK("instr", {1'b1, fword(r[10:0])}, {instr_valid, instr_word})
    end
    end_sim;
  end
endmodule
